// *** rtl/sfc_consts.vh ***
/*
  Constants of the serial flash command front end: opcodes, address layout,
  page size and the self-timed program delay.
  Assumes it is included by the design files by its bare name.
*/
`ifndef SFC_CONSTS_VH
`define SFC_CONSTS_VH

// Opcodes, shifted in most significant bit first.
`define SFC_OP_RD_FAST   8'h0B
`define SFC_OP_RD_SLOW   8'h03
`define SFC_OP_PROG      8'h02
`define SFC_OP_ERASE_4K  8'h20
`define SFC_OP_ERASE_32K 8'h52
`define SFC_OP_ERASE_64K 8'hD8
`define SFC_OP_CHIP_A    8'h60
`define SFC_OP_CHIP_B    8'hC7
`define SFC_OP_WREN      8'h06
`define SFC_OP_WRDI      8'h04
`define SFC_OP_PROT      8'h36
`define SFC_OP_UNPROT    8'h39
`define SFC_OP_RD_PROT   8'h3C
`define SFC_OP_RD_STAT   8'h05
`define SFC_OP_WR_STAT   8'h01
`define SFC_OP_RD_ID     8'h9F
`define SFC_OP_PDOWN     8'hB9
`define SFC_OP_RESUME    8'hAB

// Array address layout: 21 kept bits, sector number in the top four.
`define SFC_ADDR_W       21
`define SFC_SECT_MSB     20
`define SFC_SECT_LSB     17
`define SFC_PAGE_BYTES   256

// Status byte fields.
`define SFC_STAT_BUSY    0
`define SFC_STAT_WEL     1

// Clock rate and page_program_time.
`define SFC_CLK_MHZ      50
`define SFC_PP_TIME_US   1000

`endif

// *** rtl/sfc_sync.v ***
/*
  Two flip-flop synchroniser for a group of independent levels.
  Assumes each bit is a slow level or a clock far below the sampling rate.
*/
`timescale 1ns/100ps
module sfc_sync #(
  parameter       W       = 3,
  parameter [2:0] RST_VAL = 3'h4
) (
  input  wire         mclk_i,
  input  wire         rst_i,
  input  wire         ce_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);

  reg [W-1:0] meta;

  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      meta <= RST_VAL[W-1:0];
      q_o  <= RST_VAL[W-1:0];
    end
    else if (ce_i)
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule // sfc_sync

// *** rtl/sfc_pgbuf.v ***
/*
  Page buffer of 256 bytes with one valid bit per byte, held in flip-flops.
  Assumes clear and write never fall in the same cycle; reads take one cycle.
*/
`timescale 1ns/100ps
`include "sfc_consts.vh"
module sfc_pgbuf (
  input  wire       mclk_i,
  input  wire       rst_i,
  input  wire       ce_i,
  input  wire       clr_i,
  input  wire       wr_i,
  input  wire [7:0] waddr_i,
  input  wire [7:0] wdata_i,
  input  wire [7:0] raddr_i,
  output reg  [7:0] rdata_o,
  output reg        rvalid_o
);

  reg [7:0]                   mem [0:`SFC_PAGE_BYTES-1];
  reg [`SFC_PAGE_BYTES-1:0]   vld;

  // The data array needs no reset: a byte is only used while its valid bit is set.
  always @(posedge mclk_i)
  begin
    if (ce_i && wr_i)
      mem[waddr_i] <= wdata_i;
  end

  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      vld      <= {`SFC_PAGE_BYTES{1'b0}};
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (clr_i)
        vld <= {`SFC_PAGE_BYTES{1'b0}};
      else if (wr_i)
        vld[waddr_i] <= 1'b1;
      rdata_o  <= mem[raddr_i];
      rvalid_o <= vld[raddr_i];
    end
  end

endmodule // sfc_pgbuf

// *** rtl/sfc_flash_front.v ***
/*
  Command front end of a serial NOR flash slave: opcode framing, array read
  with wrapping address, byte/page program through a page buffer, write
  enable latch and a status byte.
  Assumes the array sits behind a same-clock port that answers a read within
  the strobe's own cycle, and that the serial clock is far slower than mclk_i.
*/
`timescale 1ns/100ps
`include "sfc_consts.vh"
module sfc_flash_front #(
  parameter [23:0] PP_CYCLES = `SFC_PP_TIME_US * `SFC_CLK_MHZ
) (
  input  wire                   mclk_i,
  input  wire                   rst_i,
  input  wire                   ce_i,
  input  wire                   cs_n_i,
  input  wire                   sck_i,
  input  wire                   si_i,
  output reg                    so_o,
  output reg                    so_oe_o,
  output reg [`SFC_ADDR_W-1:0]  mem_addr_o,
  output reg                    mem_rd_o,
  input  wire [7:0]             mem_rdata_i,
  output reg                    mem_wr_o,
  output reg [7:0]              mem_wdata_o,
  input  wire [15:0]            sect_prot_i,
  output reg                    busy_o,
  output reg                    write_enable_latch_o
);

  localparam [2:0] S_IDLE   = 3'h0;
  localparam [2:0] S_OPC    = 3'h1;
  localparam [2:0] S_ADDR   = 3'h2;
  localparam [2:0] S_DUMMY  = 3'h3;
  localparam [2:0] S_RDATA  = 3'h4;
  localparam [2:0] S_PDATA  = 3'h5;
  localparam [2:0] S_STAT   = 3'h6;
  localparam [2:0] S_IGNORE = 3'h7;

  localparam [1:0] E_IDLE   = 2'h0;
  localparam [1:0] E_RD     = 2'h1;
  localparam [1:0] E_WR     = 2'h2;
  localparam [1:0] E_WAIT   = 2'h3;

  localparam [23:0] PP_LOAD = PP_CYCLES - 24'h000001;

  // Next array address; the 21-bit sum wraps from the top to zero.
  function [`SFC_ADDR_W-1:0] inc_addr;
    input [`SFC_ADDR_W-1:0] a;
    begin
      inc_addr = a + 21'h000001;
    end
  endfunction

  wire [2:0]              pins_s;
  reg                     sck_d;
  reg                     cs_n_d;
  reg  [2:0]              state;
  reg  [7:0]              op;
  reg                     op_ok;
  reg  [6:0]              shreg;
  reg  [2:0]              bit_cnt;
  reg  [1:0]              addr_cnt;
  reg  [`SFC_ADDR_W-1:0]  addr;
  reg                     hdr_done;
  reg                     have_data;
  reg  [7:0]              pg_off;
  reg  [7:0]              out_sh;
  reg  [2:0]              out_cnt;
  reg  [7:0]              fetch;
  reg                     rd_pend;
  reg                     buf_clr;
  reg                     buf_wr;
  reg  [7:0]              buf_waddr;
  reg  [7:0]              buf_wdata;
  wire [7:0]              buf_rdata;
  wire                    buf_rvalid;
  reg  [1:0]              eng;
  reg  [7:0]              eidx;
  reg  [12:0]             prog_page;
  reg  [23:0]             wait_cnt;

  wire cs_n_s   = pins_s[2];
  wire sck_s    = pins_s[1];
  wire si_s     = pins_s[0];
  wire cs_act   = ~cs_n_s;
  wire cs_start = ~cs_n_s & cs_n_d;
  wire cs_end   = cs_n_s & ~cs_n_d;
  wire sck_rise = sck_s & ~sck_d;
  wire sck_fall = ~sck_s & sck_d;
  // Only edges matter, so the idle level of the serial clock is irrelevant.
  wire       byte_done = cs_act & sck_rise & (bit_cnt == 3'h7);
  wire [7:0] byte_in   = {shreg, si_s};
  wire [`SFC_ADDR_W-1:0] hdr_addr = {addr[12:0], byte_in};
  wire [7:0] stat_byte = {6'h00, write_enable_latch_o, busy_o};
  wire [7:0] out_load  = (state == S_STAT) ? stat_byte : fetch;
  wire [3:0] prog_sect = addr[`SFC_SECT_MSB:`SFC_SECT_LSB];

  // Pins come from the host's domain and are seen only after two flops.
  sfc_sync #(
    .W       (3),
    .RST_VAL (3'h4)
  ) u_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .d_i    ({cs_n_i, sck_i, si_i}),
    .q_o    (pins_s)
  );

  sfc_pgbuf u_pgbuf (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .clr_i    (buf_clr),
    .wr_i     (buf_wr),
    .waddr_i  (buf_waddr),
    .wdata_i  (buf_wdata),
    .raddr_i  (eidx),
    .rdata_o  (buf_rdata),
    .rvalid_o (buf_rvalid)
  );

  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      sck_d                <= 1'b0;
      cs_n_d               <= 1'b1;
      state                <= S_IDLE;
      op                   <= 8'h00;
      op_ok                <= 1'b0;
      shreg                <= 7'h00;
      bit_cnt              <= 3'h0;
      addr_cnt             <= 2'h0;
      addr                 <= 21'h000000;
      hdr_done             <= 1'b0;
      have_data            <= 1'b0;
      pg_off               <= 8'h00;
      out_sh               <= 8'h00;
      out_cnt              <= 3'h0;
      fetch                <= 8'h00;
      rd_pend              <= 1'b0;
      buf_clr              <= 1'b0;
      buf_wr               <= 1'b0;
      buf_waddr            <= 8'h00;
      buf_wdata            <= 8'h00;
      eng                  <= E_IDLE;
      eidx                 <= 8'h00;
      prog_page            <= 13'h0000;
      wait_cnt             <= 24'h000000;
      so_o                 <= 1'b0;
      so_oe_o              <= 1'b0;
      mem_addr_o           <= 21'h000000;
      mem_rd_o             <= 1'b0;
      mem_wr_o             <= 1'b0;
      mem_wdata_o          <= 8'h00;
      busy_o               <= 1'b0;
      write_enable_latch_o <= 1'b0;
    end
    else if (ce_i)
    begin
      sck_d    <= sck_s;
      cs_n_d   <= cs_n_s;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      buf_clr  <= 1'b0;
      buf_wr   <= 1'b0;
      if (rd_pend)
      begin
        fetch   <= mem_rdata_i;
        rd_pend <= 1'b0;
      end

      if (cs_start)
      begin
        state     <= S_OPC;
        op_ok     <= 1'b0;
        bit_cnt   <= 3'h0;
        addr_cnt  <= 2'h0;
        hdr_done  <= 1'b0;
        have_data <= 1'b0;
        out_cnt   <= 3'h0;
      end
      else if (cs_end)
      begin
        // A release at any point stops output at once, even mid-byte.
        state   <= S_IDLE;
        so_oe_o <= 1'b0;
        if (op_ok)
        begin
          if (op == `SFC_OP_WREN)
            write_enable_latch_o <= 1'b1;
          else if (op == `SFC_OP_WRDI)
            write_enable_latch_o <= 1'b0;
          else if (op == `SFC_OP_PROG && write_enable_latch_o)
          begin
            if (hdr_done && have_data && !sect_prot_i[prog_sect])
            begin
              eng       <= E_RD;
              eidx      <= 8'h00;
              prog_page <= addr[20:8];
              busy_o    <= 1'b1;
            end
            else
              write_enable_latch_o <= 1'b0;
          end
        end
      end
      else if (cs_act)
      begin
        if (sck_rise)
        begin
          shreg   <= byte_in[6:0];
          bit_cnt <= bit_cnt + 3'h1;
        end
        if (byte_done)
        begin
          case (state)
            S_OPC:
            begin
              op <= byte_in;
              // While busy only the status read is honoured.
              op_ok <= ~busy_o | (byte_in == `SFC_OP_RD_STAT);
              if (busy_o && byte_in != `SFC_OP_RD_STAT)
                state <= S_IGNORE;
              else
              begin
                case (byte_in)
                  `SFC_OP_RD_FAST,
                  `SFC_OP_RD_SLOW:
                    state <= S_ADDR;
                  `SFC_OP_PROG:
                  begin
                    state   <= S_ADDR;
                    buf_clr <= 1'b1;
                  end
                  `SFC_OP_RD_STAT:
                    state <= S_STAT;
                  // Framed but never acted on: no bytes are consumed here.
                  `SFC_OP_ERASE_4K, `SFC_OP_ERASE_32K, `SFC_OP_ERASE_64K,
                  `SFC_OP_CHIP_A, `SFC_OP_CHIP_B:
                    state <= S_IGNORE;
                  `SFC_OP_WREN, `SFC_OP_WRDI, `SFC_OP_PROT,
                  `SFC_OP_UNPROT, `SFC_OP_RD_PROT:
                    state <= S_IGNORE;
                  `SFC_OP_WR_STAT, `SFC_OP_RD_ID, `SFC_OP_PDOWN, `SFC_OP_RESUME:
                    state <= S_IGNORE;
                  default:
                  begin
                    state <= S_IGNORE;
                    op_ok <= 1'b0;
                  end
                endcase
              end
            end
            S_ADDR:
            begin
              addr     <= hdr_addr;
              addr_cnt <= addr_cnt + 2'h1;
              if (addr_cnt == 2'h2)
              begin
                hdr_done <= 1'b1;
                pg_off   <= byte_in;
                if (op == `SFC_OP_RD_FAST)
                  state <= S_DUMMY;
                else if (op == `SFC_OP_RD_SLOW)
                begin
                  state      <= S_RDATA;
                  mem_addr_o <= hdr_addr;
                  mem_rd_o   <= 1'b1;
                  rd_pend    <= 1'b1;
                  addr       <= inc_addr(hdr_addr);
                end
                else
                  state <= S_PDATA;
              end
            end
            S_DUMMY:
            begin
              state      <= S_RDATA;
              mem_addr_o <= addr;
              mem_rd_o   <= 1'b1;
              rd_pend    <= 1'b1;
              addr       <= inc_addr(addr);
            end
            S_PDATA:
            begin
              // The offset wraps in the page, so later bytes overwrite earlier ones.
              buf_wr    <= 1'b1;
              buf_waddr <= pg_off;
              buf_wdata <= byte_in;
              pg_off    <= pg_off + 8'h01;
              have_data <= 1'b1;
            end
            default:
            begin
              state <= state;
            end
          endcase
        end
        if (sck_fall && (state == S_RDATA || state == S_STAT))
        begin
          so_oe_o <= 1'b1;
          if (out_cnt == 3'h0)
          begin
            so_o    <= out_load[7];
            out_sh  <= {out_load[6:0], 1'b0};
            out_cnt <= 3'h7;
            if (state == S_RDATA)
            begin
              // Prefetch the next byte; it is needed eight serial clocks later.
              mem_addr_o <= addr;
              mem_rd_o   <= 1'b1;
              rd_pend    <= 1'b1;
              addr       <= inc_addr(addr);
            end
          end
          else
          begin
            so_o    <= out_sh[7];
            out_sh  <= {out_sh[6:0], 1'b0};
            out_cnt <= out_cnt - 3'h1;
          end
        end
      end

      // Self-timed program: copy valid buffer bytes, then wait out the time.
      case (eng)
        // The start is taken from the frame logic above, so this branch must not touch eng.
        E_IDLE:
          wait_cnt <= 24'h000000;
        E_RD:
          eng <= E_WR;
        E_WR:
        begin
          if (buf_rvalid)
          begin
            mem_wr_o    <= 1'b1;
            mem_addr_o  <= {prog_page, eidx};
            mem_wdata_o <= buf_rdata;
          end
          eidx <= eidx + 8'h01;
          if (eidx == 8'hFF)
          begin
            eng                  <= E_WAIT;
            wait_cnt             <= PP_LOAD;
            write_enable_latch_o <= 1'b0;
          end
          else
            eng <= E_RD;
        end
        E_WAIT:
        begin
          if (wait_cnt == 24'h000000)
          begin
            eng    <= E_IDLE;
            busy_o <= 1'b0;
          end
          else
            wait_cnt <= wait_cnt - 24'h000001;
        end
        default:
          eng <= E_IDLE;
      endcase
    end
  end

endmodule // sfc_flash_front

// *** tb/sfc_flash_front_checker.sv ***
/*
  Concurrent checks on the ports of the serial flash front end, bound to it.
  Assumes a serial clock far slower than mclk_i and several idle cycles between frames.
*/
`timescale 1ns/100ps
module sfc_flash_front_checker #(
  parameter [23:0] PP_CYCLES = 24'h00C350
) (
  input wire mclk_i,
  input wire rst_i,
  input wire cs_n_i,
  input wire sck_i,
  input wire so_o,
  input wire so_oe_o,
  input wire mem_wr_o,
  input wire busy_o,
  input wire write_enable_latch_o
);
  reg [23:0] quiet_cnt;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Cycles since the latch cleared; the self-timed wait is measured from there.
  always @(posedge mclk_i)
    if (rst_i || write_enable_latch_o)
      quiet_cnt <= 24'h000000;
    else if (quiet_cnt != 24'hFFFFFF)
      quiet_cnt <= quiet_cnt + 24'h000001;

  out_float_a: assert property ($rose(cs_n_i) |-> ##[1:6] !so_oe_o)
    else $error("serial output still driven after release");
  out_in_frame_a: assert property ($rose(so_oe_o) |-> !cs_n_i)
    else $error("serial output driven outside a frame");
  out_on_fall_a: assert property (so_oe_o && $past(so_oe_o) && $changed(so_o) |-> !sck_i)
    else $error("serial output changed while the serial clock was high");
  wr_after_end_a: assert property (mem_wr_o |-> busy_o && $past(busy_o))
    else $error("array written inside the program frame or while idle");
  wr_spaced_a: assert property (mem_wr_o |=> !mem_wr_o)
    else $error("array writes closer than two cycles");
  busy_needs_wel_a: assert property ($rose(busy_o) |-> write_enable_latch_o && $past(cs_n_i, 2))
    else $error("program started without the latch or before release");
  wel_first_a: assert property ($fell(busy_o) |-> !$past(write_enable_latch_o))
    else $error("latch still set when busy fell");
  pp_time_a: assert property ($fell(busy_o) |-> quiet_cnt == PP_CYCLES)
    else $error("program time differs from the set count");
  wel_busy_a: assert property (busy_o && !write_enable_latch_o |=> !write_enable_latch_o)
    else $error("latch set while busy");

  rd_cov_c: cover property ($rose(so_oe_o));
  pgm_cov_c: cover property ($rose(busy_o));
  wr_cov_c: cover property (mem_wr_o ##2 mem_wr_o);
endmodule // sfc_flash_front_checker

bind sfc_flash_front sfc_flash_front_checker #(.PP_CYCLES(PP_CYCLES)) chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .so_o(so_o),
  .so_oe_o(so_oe_o), .mem_wr_o(mem_wr_o), .busy_o(busy_o),
  .write_enable_latch_o(write_enable_latch_o));

// *** tb/sfc_spi_host.sv ***
/*
  Behavioural SPI master in modes 0 and 3 for the serial pins of the front end.
  Assumes the bench steps it; one bit spans eight mclk_i cycles.
*/
`timescale 1ns/100ps
module sfc_spi_host (
  input  wire mclk_i,
  input  wire so_i,
  output reg  cs_n_o,
  output reg  sck_o,
  output reg  si_o
);
  reg       idle_hi;
  reg [7:0] rx;
  event     got;

  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
    idle_hi = 1'b0;
  end

  task start(input reg m3);
    @(negedge mclk_i);
    idle_hi = m3;
    sck_o = m3;
    repeat (2) @(negedge mclk_i);
    cs_n_o = 1'b0;
    repeat (2) @(negedge mclk_i);
  endtask

  task bits(input reg [7:0] b, input integer n);
    integer i;
    for (i = 7; i > 7 - n; i--)
    begin
      sck_o = 1'b0;
      si_o = b[i];
      repeat (4) @(negedge mclk_i);
      sck_o = 1'b1;
      rx = {rx[6:0], so_i};
      repeat (4) @(negedge mclk_i);
    end
    if (n == 8)
      -> got;
  endtask

  // The data line is inverted on release so a stale level never reads as data.
  task stop;
    sck_o = idle_hi;
    repeat (2) @(negedge mclk_i);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    repeat (8) @(negedge mclk_i);
  endtask
endmodule // sfc_spi_host

// *** tb/test_serial_flash_cmd_read_program.sv ***
/*
  Self-checking bench of the serial flash front end with a master model and an array model.
  Assumes the design files and their constants header are on the include path.
*/
`timescale 1ns/100ps
module test_serial_flash_cmd_read_program;
  localparam [95:0] OPS = 96'h2052D860C736393C019FB9AB;
  reg         mclk_i;
  reg         rst_i;
  reg         ce;
  reg  [7:0]  mem_rdata_i;
  reg  [15:0] sect_prot_i;
  wire        cs_n, sck, si, so_o, so_oe_o, mem_rd_o, mem_wr_o, busy_o, write_enable_latch;
  wire [20:0] mem_addr_o;
  wire [7:0]  mem_wdata_o;
  tri1        so_pin;
  integer     mismatches, compares, k;
  reg  [23:0] a;
  reg  [15:0] rq[$];
  reg  [28:0] wq[$];
  reg  [7:0]  shadow[int];
  reg  [7:0]  arr[int];

  assign so_pin = so_oe_o ? so_o : 1'bz;
  sfc_spi_host host (.mclk_i(mclk_i), .so_i(so_pin), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
  sfc_flash_front #(.PP_CYCLES(24'h000014)) uut (
    .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
    .so_o(so_o), .so_oe_o(so_oe_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
    .mem_rdata_i(mem_rdata_i), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
    .sect_prot_i(sect_prot_i), .busy_o(busy_o), .write_enable_latch_o(write_enable_latch));

  // Sector 3 starts erased, so programs there only land on blank bytes.
  function [7:0] pat(input [20:0] p);
    pat = (p[20:17] == 4'h3) ? 8'hFF : p[7:0] ^ p[15:8] ^ {3'h0, p[20:16]} ^ 8'hA5;
  endfunction
  function [7:0] exp_b(input [20:0] p);
    exp_b = shadow.exists(p) ? shadow[p] : pat(p);
  endfunction

  // The array answers within the strobe's own cycle, so the front end captures it at the next edge.
  always @(negedge mclk_i)
  begin
    if (mem_rd_o)
      mem_rdata_i <= arr.exists(mem_addr_o) ? arr[mem_addr_o] : pat(mem_addr_o);
    if (mem_wr_o)
      arr[mem_addr_o] = mem_wdata_o;
  end

  task chk_byte(input [7:0] g);
    reg [15:0] e;
    e = rq.size() ? rq.pop_front() : {8'hFF, ~g};
    compares++;
    if ((g & e[15:8]) !== e[7:0])
    begin
      mismatches++;
      $display("MISMATCH at %0t: byte got %h exp %h", $time, g, e[7:0]);
    end
  endtask
  task chk_wr(input [28:0] g);
    reg [28:0] e;
    e = wq.size() ? wq.pop_front() : ~g;
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH at %0t: write got %h exp %h", $time, g, e);
    end
  endtask
  always @(host.got)
    chk_byte(host.rx);
  always @(negedge mclk_i)
    if (mem_wr_o === 1'b1)
      chk_wr({mem_addr_o, mem_wdata_o});

  task note(input [7:0] m, input [7:0] v);
    rq.push_back({m, v});
  endtask
  task hdr(input [7:0] op, input [23:0] ad, input integer na);
    integer j;
    note(8'hFF, 8'hFF);
    host.bits(op, 8);
    for (j = 2; j > 2 - na; j--)
    begin
      note(8'hFF, 8'hFF);
      host.bits(ad[8 * j +: 8], 8);
    end
  endtask
  task cmd(input [7:0] op, input [23:0] ad, input integer na);
    host.start(1'b0);
    hdr(op, ad, na);
    host.stop;
  endtask
  task stat(input [7:0] m, input [7:0] v);
    host.start(1'b0);
    hdr(8'h05, 24'h000000, 0);
    repeat (2)
    begin
      note(m, v);
      host.bits(8'h00, 8);
    end
    host.stop;
  endtask
  // Chip select is dropped three bits into the byte after the last one checked.
  task rd(input [7:0] op, input [23:0] ad, input integer n, input reg m3);
    integer j;
    reg [20:0] p;
    host.start(m3);
    hdr(op, ad, 3);
    if (op == 8'h0B)
    begin
      note(8'hFF, 8'hFF);
      host.bits(8'h00, 8);
    end
    p = ad[20:0];
    for (j = 0; j < n; j++)
    begin
      note(8'hFF, exp_b(p));
      host.bits(8'($urandom), 8);
      p = p + 21'h000001;
    end
    host.bits(8'h00, 3);
    host.stop;
  endtask
  task prog(input [23:0] ad, input integer n, input integer pb, input reg ok);
    integer j;
    reg [7:0] d, off;
    reg [7:0] pd[256];
    reg       pv[256];
    for (j = 0; j < 256; j++)
      pv[j] = 1'b0;
    host.start(1'b0);
    hdr(8'h02, ad, 3);
    for (j = 0; j < n; j++)
    begin
      d = 8'($urandom);
      off = ad[7:0] + j[7:0];
      pd[off] = d;
      pv[off] = 1'b1;
      note(8'hFF, 8'hFF);
      host.bits(d, 8);
    end
    if (pb > 0)
      host.bits(8'($urandom), pb);
    for (j = 0; j < 256 && ok; j++)
      if (pv[j])
      begin
        wq.push_back({ad[20:8], j[7:0], pd[j]});
        shadow[{ad[20:8], j[7:0]}] = pd[j];
      end
    host.stop;
    if (ok)
      stat(8'h01, 8'h01);
    for (j = 0; j < 5000 && busy_o !== 1'b0; j++)
      @(negedge mclk_i);
    stat(8'hFF, 8'h00);
  endtask
  task done(input [8*8-1:0] name);
    $display("test %0s done", name);
  endtask
  task conclude;
    if (rq.size() + wq.size() != 0)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h exp 0 pending results", $time, rq.size() + wq.size());
    end
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    mclk_i = 1'b0;
    forever
      #10 mclk_i = ~mclk_i;
  end
  initial
  begin
    #1500000;
    mismatches++;
    $display("MISMATCH at %0t: got 0 exp 1 watchdog", $time);
    conclude;
  end
  initial
  begin
    rst_i = 1'b1;
    ce = 1'b1;
    mem_rdata_i = 8'h00;
    sect_prot_i = 16'hFFFF;
    mismatches = 0;
    compares = 0;
    k = $urandom(71);
    repeat (16) @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    rd(8'h03, 24'hFFFFFE, 4, 1'b0);
    rd(8'h0B, {3'h5, 21'($urandom)}, 3, 1'b1);
    done("read");
    stat(8'hFF, 8'h00);
    cmd(8'h06, 24'h000000, 0);
    stat(8'hFF, 8'h02);
    cmd(8'h04, 24'h000000, 0);
    stat(8'hFF, 8'h00);
    host.start(1'b0);
    host.bits(8'h06, 5);
    host.stop;
    host.start(1'b0);
    hdr(8'h5A, 24'h060606, 3);
    host.stop;
    for (k = 0; k < 12; k++)
      cmd(OPS[8 * (11 - k) +: 8], 24'($urandom), (k < 3 || (k > 4 && k < 8)) ? 3 : 0);
    // A frame sent while the clock enable is low must leave no trace.
    ce = 1'b0;
    cmd(8'h06, 24'h000000, 0);
    ce = 1'b1;
    stat(8'hFF, 8'h00);
    done("latch");
    sect_prot_i = 16'($urandom);
    sect_prot_i[3] = 1'b0;
    sect_prot_i[5] = 1'b1;
    a = {3'h7, 4'h3, 9'($urandom), 8'hFE};
    cmd(8'h06, 24'h000000, 0);
    prog(a, 3, 5, 1'b1);
    rd(8'h03, {a[23:8], 8'hFD}, 3, 1'b0);
    rd(8'h0B, {a[23:8], 8'h00}, 2, 1'b0);
    cmd(8'h06, 24'h000000, 0);
    prog({a[23:17], 9'($urandom), 8'h00}, 258, 0, 1'b1);
    done("program");
    cmd(8'h06, 24'h000000, 0);
    prog({3'h0, 4'h5, 17'($urandom)}, 2, 0, 1'b0);
    cmd(8'h06, 24'h000000, 0);
    host.start(1'b0);
    hdr(8'h02, a, 2);
    host.stop;
    stat(8'hFF, 8'h00);
    cmd(8'h06, 24'h000000, 0);
    prog(a, 0, 5, 1'b0);
    prog(a, 1, 0, 1'b0);
    done("abort");
    repeat (20) @(negedge mclk_i);
    conclude;
  end
endmodule // test_serial_flash_cmd_read_program
